// >>> rtl/charge_sequencer.sv
// Charge-cycle sequencer: state machine, safety timers and status pin
`timescale 1ns/100ps
`default_nettype none

module charge_sequencer #(
  parameter int unsigned TICK_CYCLES        = chg_seq_pkg::TICK_CYCLES,
  parameter int unsigned TERM_FILTER_CYCLES = chg_seq_pkg::TERM_FILTER_CYCLES,
  parameter int unsigned PRECOND_TICKS      = chg_seq_pkg::PRECOND_TICKS,
  parameter int unsigned ELAPSED_STEP_TICKS = chg_seq_pkg::ELAPSED_STEP_TICKS
) (
  // Clock and reset
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_rst_n,
  // Analog comparators
  input  wire chg_seq_pkg::cmp_t                 i_cmp,
  // Register port
  input  wire logic [chg_seq_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [chg_seq_pkg::DATA_W-1:0]    i_wr_data,
  input  wire logic                              i_wr_en,
  input  wire logic                              i_rd_en,
  output var  logic [chg_seq_pkg::DATA_W-1:0]    o_rd_data,
  // Analog charger commands
  output var  chg_seq_pkg::chg_cmd_t             o_chg_cmd,
  // Open-drain status pin
  output var  logic                              o_stat_out,
  output var  logic                              o_stat_oe
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  chg_seq_pkg::cmp_t                 sync1_reg;
  chg_seq_pkg::cmp_t                 cmp_reg;
  chg_seq_pkg::state_t               state_reg;
  chg_seq_pkg::state_t               state_next;
  logic [chg_seq_pkg::DATA_W-1:0]    cfg_reg;
  logic [chg_seq_pkg::TIMER_W-1:0]   timer_reg;
  logic [chg_seq_pkg::CNT_W-1:0]     filt_cnt_reg;
  logic                              filt_done_reg;
  logic [chg_seq_pkg::FLASH_W-1:0]   flash_cnt_reg;
  logic                              flash_phase_reg;
  logic                              tick;
  logic                              pre_expired;
  logic                              elapsed_expired;
  logic                              timer_restart;
  logic [1:0]                        elapsed_sel;

  function automatic logic [chg_seq_pkg::TIMER_W-1:0] elapsed_limit(input logic [1:0] sel);
    elapsed_limit = chg_seq_pkg::TIMER_W'(sel) * chg_seq_pkg::TIMER_W'(ELAPSED_STEP_TICKS);
  endfunction
  function automatic logic is_charging(input chg_seq_pkg::state_t st);
    is_charging = st inside {chg_seq_pkg::ST_PRECOND, chg_seq_pkg::ST_FAST, chg_seq_pkg::ST_CV};
  endfunction
  function automatic logic is_fault(input chg_seq_pkg::state_t st);
    is_fault = (st == chg_seq_pkg::ST_TEMP_FAULT) || (st == chg_seq_pkg::ST_TIMER_FAULT) ||
               (st == chg_seq_pkg::ST_PRE_FAULT);
  endfunction
  // Precharge is skipped when the option is off
  function automatic chg_seq_pkg::state_t start_state(input chg_seq_pkg::cmp_t c,
                                                      input logic pre_en);
    if (c.below_short) begin
      start_state = chg_seq_pkg::ST_SHORT;
    end else if (c.below_precond && pre_en) begin
      start_state = chg_seq_pkg::ST_PRECOND;
    end else begin
      start_state = chg_seq_pkg::ST_FAST;
    end
  endfunction

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sync1_reg <= '0;
      cmp_reg   <= '0;
    end else begin
      sync1_reg <= i_cmp;
      cmp_reg   <= sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Timer tick
  // ---------------------------------------------------------------
  tick_divider #(.CYCLES (TICK_CYCLES)) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .o_tick    (tick)
  );

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cfg_reg <= chg_seq_pkg::CFG_RESET;
    end else if (i_wr_en && (i_addr == chg_seq_pkg::OFS_CFG)) begin
      cfg_reg <= i_wr_data & chg_seq_pkg::CFG_MASK;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_rd_en) begin
      o_rd_data <= '0;
    end else begin
      case (i_addr)
        chg_seq_pkg::OFS_CFG:    o_rd_data <= cfg_reg;
        chg_seq_pkg::OFS_STATUS: o_rd_data <= {28'h0000000, state_reg};
        chg_seq_pkg::OFS_TIMER:  o_rd_data <= {6'h00, timer_reg};
        default:                 o_rd_data <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Safety timers
  // ---------------------------------------------------------------
  // A zero select disables the elapsed timer
  assign elapsed_sel     = cfg_reg[chg_seq_pkg::CFG_ELAPSED_LO +: 2];
  assign pre_expired     = cfg_reg[chg_seq_pkg::CFG_PTIMER_EN] &&
                           (timer_reg >= chg_seq_pkg::TIMER_W'(PRECOND_TICKS));
  assign elapsed_expired = (elapsed_sel != 2'h0) &&
                           (timer_reg >= elapsed_limit(elapsed_sel));
  // Elapsed time spans fast charge and constant voltage together
  assign timer_restart   = (state_next != state_reg) &&
                           ((state_next == chg_seq_pkg::ST_FAST) ||
                            (state_next == chg_seq_pkg::ST_PRECOND));
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      timer_reg <= '0;
    end else if (timer_restart) begin
      timer_reg <= '0;
    end else if (tick && is_charging(state_reg) && !(&timer_reg)) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Termination filter
  // ---------------------------------------------------------------
  // Any dip in the low-current flag restarts the count
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      filt_cnt_reg  <= '0;
      filt_done_reg <= 1'b0;
    end else if ((state_reg != chg_seq_pkg::ST_CV) || !cmp_reg.ichg_below_term) begin
      filt_cnt_reg  <= '0;
      filt_done_reg <= 1'b0;
    end else if (filt_cnt_reg == chg_seq_pkg::CNT_W'(TERM_FILTER_CYCLES - 1)) begin
      filt_done_reg <= 1'b1;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (!cmp_reg.supply_ok) begin
      state_next = chg_seq_pkg::ST_SHUTDOWN;
    end else if (cmp_reg.program_pin_high_z && !is_fault(state_reg)) begin
      state_next = chg_seq_pkg::ST_STANDBY;
    end else begin
      case (state_reg)
        chg_seq_pkg::ST_SHUTDOWN: state_next = chg_seq_pkg::ST_STANDBY;
        chg_seq_pkg::ST_STANDBY: begin
          if (cmp_reg.bat_present && cmp_reg.below_recharge) begin
            state_next = start_state(cmp_reg, cfg_reg[chg_seq_pkg::CFG_PRE_EN]);
          end
        end
        chg_seq_pkg::ST_SHORT: begin
          if (!cmp_reg.bat_present) begin
            state_next = chg_seq_pkg::ST_STANDBY;
          end else if (cmp_reg.die_over_temp) begin
            state_next = chg_seq_pkg::ST_TEMP_FAULT;
          end else if (cmp_reg.above_short_hyst) begin
            state_next = cfg_reg[chg_seq_pkg::CFG_PRE_EN] ?
                         chg_seq_pkg::ST_PRECOND : chg_seq_pkg::ST_FAST;
          end
        end
        chg_seq_pkg::ST_PRECOND, chg_seq_pkg::ST_FAST, chg_seq_pkg::ST_CV: begin
          if (!cmp_reg.bat_present) begin
            state_next = chg_seq_pkg::ST_STANDBY;
          end else if (cmp_reg.die_over_temp) begin
            state_next = chg_seq_pkg::ST_TEMP_FAULT;
          end else if (cmp_reg.below_short) begin
            state_next = chg_seq_pkg::ST_SHORT;
          end else if (state_reg == chg_seq_pkg::ST_PRECOND) begin
            if (pre_expired) begin
              state_next = chg_seq_pkg::ST_PRE_FAULT;
            end else if (!cmp_reg.below_precond) begin
              state_next = chg_seq_pkg::ST_FAST;
            end
          end else if (state_reg == chg_seq_pkg::ST_FAST) begin
            if (elapsed_expired) begin
              state_next = chg_seq_pkg::ST_TIMER_FAULT;
            end else if (cmp_reg.at_regulation) begin
              state_next = chg_seq_pkg::ST_CV;
            end
          end else if (filt_done_reg || elapsed_expired) begin
            state_next = cfg_reg[chg_seq_pkg::CFG_RECHG_EN] ?
                         chg_seq_pkg::ST_DONE : chg_seq_pkg::ST_HALT;
          end
        end
        chg_seq_pkg::ST_DONE: begin
          if (!cmp_reg.bat_present) begin
            state_next = chg_seq_pkg::ST_STANDBY;
          end else if (cmp_reg.below_recharge) begin
            state_next = chg_seq_pkg::ST_FAST;
          end
        end
        chg_seq_pkg::ST_HALT: begin
          // Only removal, power loss or program pin release restart
          if (!cmp_reg.bat_present) begin
            state_next = chg_seq_pkg::ST_STANDBY;
          end
        end
        chg_seq_pkg::ST_TEMP_FAULT: begin
          if (!cmp_reg.die_over_temp) begin
            state_next = chg_seq_pkg::ST_STANDBY;
          end
        end
        chg_seq_pkg::ST_TIMER_FAULT, chg_seq_pkg::ST_PRE_FAULT: begin
          if (!cmp_reg.bat_present) begin
            state_next = chg_seq_pkg::ST_STANDBY;
          end
        end
        default: state_next = chg_seq_pkg::ST_SHUTDOWN;
      endcase
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_reg <= chg_seq_pkg::ST_SHUTDOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Charger commands
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_chg_cmd <= '0;
    end else begin
      o_chg_cmd.enable     <= is_charging(state_reg) || (state_reg == chg_seq_pkg::ST_SHORT);
      o_chg_cmd.precond    <= (state_reg == chg_seq_pkg::ST_PRECOND);
      o_chg_cmd.fast       <= (state_reg == chg_seq_pkg::ST_FAST);
      o_chg_cmd.const_volt <= (state_reg == chg_seq_pkg::ST_CV);
      o_chg_cmd.detect     <= (state_reg == chg_seq_pkg::ST_SHORT);
      o_chg_cmd.term_sel   <= cfg_reg[chg_seq_pkg::CFG_TERM_LO +: 2];
      o_chg_cmd.dual_cell  <= cfg_reg[chg_seq_pkg::CFG_DUAL_CELL];
    end
  end

  // ---------------------------------------------------------------
  // Status pin
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !is_fault(state_reg)) begin
      flash_cnt_reg   <= '0;
      flash_phase_reg <= 1'b0;
    end else if (tick) begin
      if (flash_cnt_reg == chg_seq_pkg::FLASH_W'(chg_seq_pkg::FLASH_HALF_MS - 1)) begin
        flash_cnt_reg   <= '0;
        flash_phase_reg <= !flash_phase_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 1'b1;
      end
    end
  end

  // Pin level is fixed low; only the enable moves, so it never drives high
  always_ff @(posedge i_ref_clk) begin
    o_stat_out <= 1'b0;
    if (!i_rst_n) begin
      o_stat_oe <= 1'b0;
    end else if (is_charging(state_reg)) begin
      o_stat_oe <= 1'b1;
    end else if (is_fault(state_reg)) begin
      o_stat_oe <= cfg_reg[chg_seq_pkg::CFG_FLASH_EN] && flash_phase_reg;
    end else begin
      o_stat_oe <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_supply_forces_off: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !cmp_reg.supply_ok |=> (state_reg == chg_seq_pkg::ST_SHUTDOWN) ##1 !o_chg_cmd.enable)
    else $error("supply loss did not shut the charger down");
  a_program_pin_standby: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmp_reg.supply_ok && cmp_reg.program_pin_high_z && !is_fault(state_reg))
      |=> (state_reg == chg_seq_pkg::ST_STANDBY))
    else $error("high-impedance program pin did not give standby");
  a_stat_never_high: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_stat_out == 1'b0)
    else $error("status pin would drive high");
  a_stat_while_charging: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    is_charging(state_reg) |=> o_stat_oe)
    else $error("status pin not pulled low while charging");
  a_fast_timer_cleared: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (state_reg != chg_seq_pkg::ST_FAST) ##1 (state_reg == chg_seq_pkg::ST_FAST)
      |-> (timer_reg == '0))
    else $error("elapsed timer not restarted on fast-charge entry");
  a_pre_fault_holds: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (state_reg == chg_seq_pkg::ST_PRE_FAULT && cmp_reg.supply_ok && cmp_reg.bat_present)
      |=> (state_reg == chg_seq_pkg::ST_PRE_FAULT) ##1 !o_chg_cmd.enable)
    else $error("precharge timer fault released early");
  a_short_detect_only: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (state_reg == chg_seq_pkg::ST_SHORT)
      |=> (o_chg_cmd.detect && !o_chg_cmd.fast && !o_chg_cmd.precond))
    else $error("shorted battery got more than detection current");
  a_term_filter_reset: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !cmp_reg.ichg_below_term |=> (filt_cnt_reg == '0) && !filt_done_reg)
    else $error("termination filter did not restart");
  a_over_temp_stop: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (is_charging(state_reg) && cmp_reg.supply_ok && !cmp_reg.program_pin_high_z &&
     cmp_reg.bat_present && cmp_reg.die_over_temp)
      |=> (state_reg == chg_seq_pkg::ST_TEMP_FAULT) ##1 !o_chg_cmd.enable)
    else $error("over-temperature did not suspend charge");
  a_cv_from_fast: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(state_reg == chg_seq_pkg::ST_CV) |-> $past(state_reg) == chg_seq_pkg::ST_FAST)
    else $error("constant voltage entered from wrong state");

endmodule // charge_sequencer
`default_nettype wire

// >>> rtl/chg_seq_pkg.sv
// Shared constants and types of the charge-cycle sequencer
package chg_seq_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ       = 200;
  localparam int unsigned TICK_TIME_US       = 1000;
  localparam int unsigned TICK_CYCLES        = TICK_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned TERM_FILTER_US     = 1000;
  localparam int unsigned TERM_FILTER_CYCLES = TERM_FILTER_US * CLK_FREQ_MHZ;
  localparam int unsigned MS_PER_MIN         = 60000;
  localparam int unsigned PRECOND_TIME_MIN   = 32;
  localparam int unsigned PRECOND_TICKS      = PRECOND_TIME_MIN * MS_PER_MIN;
  localparam int unsigned ELAPSED_STEP_MIN   = 120;
  localparam int unsigned ELAPSED_STEP_TICKS = ELAPSED_STEP_MIN * MS_PER_MIN;
  localparam int unsigned FLASH_PERIOD_MS    = 1600;
  localparam int unsigned FLASH_HALF_MS      = FLASH_PERIOD_MS / 2;

  localparam int unsigned CNT_W   = 18;
  localparam int unsigned TIMER_W = 26;
  localparam int unsigned FLASH_W = 10;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned   ADDR_W     = 8;
  localparam int unsigned   DATA_W     = 32;
  localparam logic [7:0]    OFS_CFG    = 8'h00;
  localparam logic [7:0]    OFS_STATUS = 8'h04;
  localparam logic [7:0]    OFS_TIMER  = 8'h08;
  localparam logic [31:0]   CFG_RESET  = 32'h000000b7;
  localparam logic [31:0]   CFG_MASK   = 32'h000001ff;

  // Config fields
  localparam int unsigned CFG_PRE_EN     = 0;
  localparam int unsigned CFG_PTIMER_EN  = 1;
  localparam int unsigned CFG_ELAPSED_LO = 2;
  localparam int unsigned CFG_RECHG_EN   = 4;
  localparam int unsigned CFG_FLASH_EN   = 5;
  localparam int unsigned CFG_TERM_LO    = 6;
  localparam int unsigned CFG_DUAL_CELL  = 8;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SHUTDOWN, ST_STANDBY, ST_SHORT, ST_PRECOND, ST_FAST, ST_CV,
    ST_DONE, ST_HALT, ST_TEMP_FAULT, ST_TIMER_FAULT, ST_PRE_FAULT
  } state_t;

  // Comparator results from the analog charger
  typedef struct packed {
    logic supply_ok;
    logic program_pin_high_z;
    logic bat_present;
    logic below_precond;
    logic at_regulation;
    logic below_recharge;
    logic below_short;
    logic above_short_hyst;
    logic ichg_below_term;
    logic die_over_temp;
  } cmp_t;

  // Commands to the analog charger
  typedef struct packed {
    logic       enable;
    logic       precond;
    logic       fast;
    logic       const_volt;
    logic       detect;
    logic [1:0] term_sel;
    logic       dual_cell;
  } chg_cmd_t;

endpackage

// >>> rtl/tick_divider.sv
// Divides the reference clock into a one-cycle timer tick
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int unsigned CYCLES = chg_seq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Tick
  output var  logic o_tick
);

  logic [chg_seq_pkg::CNT_W-1:0] cnt_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else if (cnt_reg == chg_seq_pkg::CNT_W'(CYCLES - 1)) begin
      cnt_reg <= '0;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      o_tick  <= 1'b0;
    end
  end

endmodule // tick_divider
`default_nettype wire

// >>> test/stat_pullup.sv
// Pull-up model of the LED or host input on the status pin
`timescale 1ns/100ps
`default_nettype none
module stat_pullup (
  // Pin drive from the sequencer
  input  wire logic i_stat_out,
  input  wire logic i_stat_oe,
  // Level seen by the far side
  output var  logic o_level
);
  // Released pin goes to the pull-up level, not the last driven value
  always_comb o_level = i_stat_oe ? i_stat_out : 1'b1;
endmodule // stat_pullup
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench of the charge-cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                  i_ref_clk;
  logic                  i_rst_n;
  chg_seq_pkg::cmp_t     cmp;
  logic [7:0]            addr;
  logic [31:0]           wdata;
  logic                  wr_en;
  logic                  rd_en;
  logic [31:0]           rd_data;
  chg_seq_pkg::chg_cmd_t chg_cmd;
  logic                  stat_out;
  logic                  stat_oe;
  logic                  stat_level;
  logic [31:0]           d;
  int                    fails;
  int                    n_compared;

  // Short counts keep the run small
  charge_sequencer #(.TICK_CYCLES(4), .TERM_FILTER_CYCLES(8), .PRECOND_TICKS(20),
    .ELAPSED_STEP_TICKS(30)) i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_cmp(cmp), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .o_rd_data(rd_data), .o_chg_cmd(chg_cmd), .o_stat_out(stat_out), .o_stat_oe(stat_oe));
  stat_pullup i_pin (.i_stat_out(stat_out), .i_stat_oe(stat_oe), .o_level(stat_level));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge i_ref_clk);
    wr_en <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge i_ref_clk);
    rd_en <= 1'b0;
    @(negedge i_ref_clk);
    v = rd_data;
  endtask

  task automatic want(input logic [3:0] s, input int polls);
    for (int i = 0; i < polls; i++) begin
      reg_rd(chg_seq_pkg::OFS_STATUS, d);
      if (d[3:0] === s) break;
    end
    check("state", {28'h0, s}, d);
  endtask

  // Mode bits: enable, precond, fast, const_volt, detect
  task automatic outs(input logic [4:0] m, input logic [4:0] mask, input logic lvl);
    @(negedge i_ref_clk);
    check("mode", {27'h0, m}, {27'h0, chg_cmd[7:3] & mask});
    check("stat level", {31'h0, lvl}, {31'h0, stat_level});
    check("stat drive", 32'h0, {31'h0, stat_out});
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    fails = 0;
    n_compared = 0;
    i_rst_n = 1'b0;
    cmp = '0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    reg_rd(chg_seq_pkg::OFS_CFG, d);
    check("cfg reset", chg_seq_pkg::CFG_RESET, d);
    reg_rd(8'h0c, d);
    check("unmapped", 32'h0, d);
    reg_wr(chg_seq_pkg::OFS_STATUS, 32'h0000ffff);
    reg_wr(chg_seq_pkg::OFS_CFG, 32'hfffffeb7);
    reg_rd(chg_seq_pkg::OFS_CFG, d);
    check("cfg mask", 32'h000000b7, d);
    want(chg_seq_pkg::ST_SHUTDOWN, 1);
    @(posedge i_ref_clk) cmp.supply_ok <= 1'b1;
    want(chg_seq_pkg::ST_STANDBY, 4);
    outs(5'h00, 5'h1f, 1'b1);
    @(posedge i_ref_clk) {cmp.bat_present, cmp.below_recharge, cmp.below_precond} <= 3'h7;
    want(chg_seq_pkg::ST_PRECOND, 4);
    outs(5'h18, 5'h1f, 1'b0);
    repeat (60) @(posedge i_ref_clk);
    want(chg_seq_pkg::ST_PRECOND, 1);
    want(chg_seq_pkg::ST_PRE_FAULT, 15);
    outs(5'h00, 5'h1f, 1'b1);
    reg_rd(chg_seq_pkg::OFS_TIMER, d);
    check("timer", 32'h00000014, d);
    @(posedge i_ref_clk) cmp.program_pin_high_z <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    want(chg_seq_pkg::ST_PRE_FAULT, 1);
    @(posedge i_ref_clk) cmp.program_pin_high_z <= 1'b0;
    // Flash half period is 800 ticks of 4 cycles
    repeat (3250) @(posedge i_ref_clk);
    outs(5'h00, 5'h1f, 1'b0);
    @(posedge i_ref_clk) cmp.bat_present <= 1'b0;
    want(chg_seq_pkg::ST_STANDBY, 4);
    @(posedge i_ref_clk) cmp.bat_present <= 1'b1;
    want(chg_seq_pkg::ST_PRECOND, 4);
    repeat (50) @(posedge i_ref_clk);
    @(posedge i_ref_clk) cmp.below_precond <= 1'b0;
    want(chg_seq_pkg::ST_FAST, 4);
    outs(5'h14, 5'h1f, 1'b0);
    repeat (100) @(posedge i_ref_clk);
    want(chg_seq_pkg::ST_FAST, 1);
    want(chg_seq_pkg::ST_TIMER_FAULT, 15);
    outs(5'h00, 5'h1f, 1'b1);
    @(posedge i_ref_clk) cmp.bat_present <= 1'b0;
    want(chg_seq_pkg::ST_STANDBY, 4);
    reg_wr(chg_seq_pkg::OFS_CFG, 32'h000000b3);
    @(posedge i_ref_clk) cmp.bat_present <= 1'b1;
    want(chg_seq_pkg::ST_FAST, 4);
    @(posedge i_ref_clk) {cmp.below_recharge, cmp.at_regulation} <= 2'b01;
    want(chg_seq_pkg::ST_CV, 4);
    outs(5'h12, 5'h1f, 1'b0);
    check("term sel", 32'h4, {29'h0, chg_cmd[2:0]});
    @(posedge i_ref_clk) cmp.ichg_below_term <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    cmp.ichg_below_term <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    want(chg_seq_pkg::ST_CV, 1);
    @(posedge i_ref_clk) cmp.ichg_below_term <= 1'b1;
    want(chg_seq_pkg::ST_DONE, 8);
    outs(5'h00, 5'h1f, 1'b1);
    @(posedge i_ref_clk) {cmp.at_regulation, cmp.ichg_below_term, cmp.below_recharge} <= 3'b001;
    want(chg_seq_pkg::ST_FAST, 4);
    @(posedge i_ref_clk) {cmp.die_over_temp, cmp.below_recharge} <= 2'b10;
    want(chg_seq_pkg::ST_TEMP_FAULT, 4);
    outs(5'h00, 5'h1f, 1'b1);
    @(posedge i_ref_clk) cmp.die_over_temp <= 1'b0;
    want(chg_seq_pkg::ST_STANDBY, 4);
    @(posedge i_ref_clk) {cmp.below_short, cmp.below_recharge, cmp.below_precond} <= 3'h7;
    want(chg_seq_pkg::ST_SHORT, 4);
    outs(5'h11, 5'h1f, 1'b1);
    @(posedge i_ref_clk) cmp.below_short <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    want(chg_seq_pkg::ST_SHORT, 1);
    @(posedge i_ref_clk) cmp.above_short_hyst <= 1'b1;
    want(chg_seq_pkg::ST_PRECOND, 4);
    reg_wr(chg_seq_pkg::OFS_CFG, 32'h000001a3);
    @(posedge i_ref_clk) {cmp.below_precond, cmp.at_regulation, cmp.ichg_below_term} <= 3'b011;
    want(chg_seq_pkg::ST_HALT, 10);
    outs(5'h00, 5'h1f, 1'b1);
    check("dual cell", 32'h00000001, {31'h0, chg_cmd[0]});
    @(posedge i_ref_clk) cmp.program_pin_high_z <= 1'b1;
    want(chg_seq_pkg::ST_STANDBY, 4);
    @(posedge i_ref_clk) {cmp.at_regulation, cmp.ichg_below_term} <= 2'b00;
    repeat (10) @(posedge i_ref_clk);
    want(chg_seq_pkg::ST_STANDBY, 1);
    @(posedge i_ref_clk) cmp.program_pin_high_z <= 1'b0;
    want(chg_seq_pkg::ST_FAST, 4);
    @(posedge i_ref_clk) cmp.supply_ok <= 1'b0;
    want(chg_seq_pkg::ST_SHUTDOWN, 4);
    outs(5'h00, 5'h1f, 1'b1);
    test_done();
  end

  // Whole sequence needs well under 6000 cycles
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    fails++;
    test_done();
  end
endmodule // testbench
`default_nettype wire
